// ==== include/bmv_regs.svh ====
// Constants for the bidirectional motion vector derivation block
`ifndef BMV_REGS_SVH
`define BMV_REGS_SVH
`define BMV_MV_W        12
`define BMV_DIST_W      8
`define BMV_REF_W       4
`define BMV_KIND_W      5
`define BMV_SIZE_W      3
`define BMV_CNT_W       5
`define BMV_IDX_W       4
`define BMV_PROD_W      24
`define BMV_KIND_DIRECT 5'h00
`define BMV_KIND_BIDIR  5'h03
`define BMV_KIND_FIRST_UNI 5'h01
`define BMV_KIND_LAST_UNI  5'h0F
`define BMV_SIZE_16X16  3'h0
`define BMV_SIZE_16X8   3'h1
`define BMV_SIZE_8X16   3'h2
`define BMV_SIZE_8X8    3'h3
`define BMV_SIZE_8X4    3'h4
`define BMV_SIZE_4X8    3'h5
`define BMV_SIZE_4X4    3'h6
`define BMV_CNT_1       5'h01
`define BMV_CNT_2       5'h02
`define BMV_CNT_4       5'h04
`define BMV_CNT_8       5'h08
`define BMV_CNT_16      5'h10
`define BMV_NB_NUM      3
`endif

// ==== include/bmv_pkg.sv ====
// Types for the bidirectional motion vector derivation block
`include "bmv_regs.svh"
package bmv_pkg;
   typedef enum logic [3:0] {
      BMV_IDLE = 4'h1,
      BMV_FWD  = 4'h2,
      BMV_BWD  = 4'h4,
      BMV_DIR  = 4'h8
   } bmv_state_t;

   typedef struct packed {
      bmv_state_t                   state;
      logic [`BMV_CNT_W-1:0]        cnt;
      logic [`BMV_CNT_W-1:0]        total;
      logic [`BMV_SIZE_W-1:0]       shape;
      logic [`BMV_SIZE_W-1:0]       bwd_shape;
      logic                         need_bwd;
      logic                         phase;
      logic                         zero_dir;
      logic [`BMV_REF_W-1:0]        fwd_ref;
      logic signed [`BMV_MV_W-1:0]  last_x;
      logic signed [`BMV_MV_W-1:0]  last_y;
      logic signed [`BMV_MV_W-1:0]  pend_x;
      logic signed [`BMV_MV_W-1:0]  pend_y;
      logic                         vd_ready;
      logic                         mv_valid;
      logic                         mv_dir;
      logic [`BMV_IDX_W-1:0]        mv_blk;
      logic [`BMV_SIZE_W-1:0]       mv_shape;
      logic signed [`BMV_MV_W-1:0]  mv_x;
      logic signed [`BMV_MV_W-1:0]  mv_y;
      logic [`BMV_REF_W-1:0]        mv_ref;
      logic [`BMV_IDX_W-1:0]        col_idx;
      logic                         mb_done;
      logic                         busy;
   } bmv_st_t;
endpackage

// ==== hw/bmv_derive.sv ====
// Forward/backward motion vector derivation for bidirectionally predicted macroblocks
`timescale 1ns/1ps
`default_nettype none
`include "bmv_regs.svh"

// Summary of operation
// - Forward differences taken only for forward/bi kinds, backward only for backward/bi.
// - One to sixteen difference sets per direction, from kind or bi size code.
// - Final vector is received difference plus neighbour-based predicted vector.
// - Forward predictor uses forward neighbours only; backward uses backward only.
// - Neighbour lacking a vector of that direction contributes zero.
// - Direct macroblock copies co-located macroblock partitioning.
// - Direct sub-block vectors scale the matching co-located vector components.
// - Forward is distB*mv/distD; backward is (distB-distD)*mv/distD.
// - Intra next picture or intra co-located macroblock forces direct vectors zero.
// - Divisor is previous-to-next distance, multiplier current-to-previous distance.
// - Multi-reference direct forward reference equals co-located reference frame.
// - Multi-reference distances are measured against co-located reference frame.
// - Direct kind takes no difference data, vectors come from direct derivation.
// - Bi kind carries separate forward/backward size codes 0..6, 16x16 to 4x4.
module bmv_derive
   import bmv_pkg::*;
(
   input  wire logic                                     clk_i,
   input  wire logic                                     rst_i,
   input  wire logic                                     ce_i,
   input  wire logic                                     mb_start_i,
   input  wire logic [`BMV_KIND_W-1:0]                   macroblock_kind_i,
   input  wire logic [`BMV_SIZE_W-1:0]                   fwd_blk_size_i,
   input  wire logic [`BMV_SIZE_W-1:0]                   bwd_blk_size_i,
   input  wire logic [`BMV_REF_W-1:0]                    ref_frame_i,
   input  wire logic                                     multi_ref_i,
   input  wire logic                                     vd_valid_i,
   input  wire logic signed [`BMV_MV_W-1:0]              fwd_vector_diff_x_i,
   input  wire logic signed [`BMV_MV_W-1:0]              fwd_vector_diff_y_i,
   input  wire logic signed [`BMV_MV_W-1:0]              bwd_vector_diff_x_i,
   input  wire logic signed [`BMV_MV_W-1:0]              bwd_vector_diff_y_i,
   input  wire logic [`BMV_NB_NUM-1:0][`BMV_MV_W-1:0]    nb_fwd_x_i,
   input  wire logic [`BMV_NB_NUM-1:0][`BMV_MV_W-1:0]    nb_fwd_y_i,
   input  wire logic [`BMV_NB_NUM-1:0]                   nb_fwd_ok_i,
   input  wire logic [`BMV_NB_NUM-1:0][`BMV_MV_W-1:0]    nb_bwd_x_i,
   input  wire logic [`BMV_NB_NUM-1:0][`BMV_MV_W-1:0]    nb_bwd_y_i,
   input  wire logic [`BMV_NB_NUM-1:0]                   nb_bwd_ok_i,
   input  wire logic [`BMV_SIZE_W-1:0]                   col_size_i,
   input  wire logic                                     col_intra_i,
   input  wire logic                                     next_ref_intra_i,
   input  wire logic [`BMV_REF_W-1:0]                    col_ref_i,
   input  wire logic signed [`BMV_MV_W-1:0]              col_mv_x_i,
   input  wire logic signed [`BMV_MV_W-1:0]              col_mv_y_i,
   input  wire logic [`BMV_DIST_W-1:0]                   cur_to_prev_distance_i,
   input  wire logic [`BMV_DIST_W-1:0]                   prev_to_next_distance_i,
   input  wire logic [`BMV_DIST_W-1:0]                   ref_gap_i,
   output logic                                          vd_ready_o,
   output logic                                          busy_o,
   output logic [`BMV_IDX_W-1:0]                         col_idx_o,
   output logic                                          mv_valid_o,
   output logic                                          mv_dir_o,
   output logic [`BMV_IDX_W-1:0]                         mv_blk_o,
   output logic [`BMV_SIZE_W-1:0]                        mv_shape_o,
   output logic signed [`BMV_MV_W-1:0]                   mv_x_o,
   output logic signed [`BMV_MV_W-1:0]                   mv_y_o,
   output logic [`BMV_REF_W-1:0]                         mv_ref_o,
   output logic                                          mb_done_o
);

   // Number of sub-blocks for a block-size code
   function automatic logic [`BMV_CNT_W-1:0] blk_count(input logic [`BMV_SIZE_W-1:0] sz);
      unique case (sz)
         `BMV_SIZE_16X16: blk_count = `BMV_CNT_1;
         `BMV_SIZE_16X8,
         `BMV_SIZE_8X16:  blk_count = `BMV_CNT_2;
         `BMV_SIZE_8X8:   blk_count = `BMV_CNT_4;
         `BMV_SIZE_8X4,
         `BMV_SIZE_4X8:   blk_count = `BMV_CNT_8;
         default:         blk_count = `BMV_CNT_16;
      endcase
   endfunction

   // Size code of a single-direction kind; codes pair up as fwd/bwd
   function automatic logic [`BMV_SIZE_W-1:0] uni_size(input logic [`BMV_KIND_W-1:0] k);
      logic [`BMV_KIND_W-1:0] h;
      h = k >> 1;
      uni_size = (h == `BMV_KIND_W'(0)) ? `BMV_SIZE_16X16 : `BMV_SIZE_W'(h - `BMV_KIND_W'(1));
   endfunction

   // Median of three signed components
   function automatic logic signed [`BMV_MV_W-1:0] med3(input logic signed [`BMV_MV_W-1:0] a,
                                                        input logic signed [`BMV_MV_W-1:0] b,
                                                        input logic signed [`BMV_MV_W-1:0] c);
      // Ties resolve to a repeated value, never to the odd one out
      if ((a >= b && a <= c) || (a <= b && a >= c))
         med3 = a;
      else if ((b >= a && b <= c) || (b <= a && b >= c))
         med3 = b;
      else
         med3 = c;
   endfunction

   // Direct-mode scaling: signed product then truncating divide
   function automatic logic signed [`BMV_MV_W-1:0] scale(input logic signed [`BMV_PROD_W-1:0] num,
                                                         input logic signed [`BMV_PROD_W-1:0] mv,
                                                         input logic signed [`BMV_PROD_W-1:0] den);
      logic signed [`BMV_PROD_W-1:0] q;
      q = (den == `BMV_PROD_W'(0)) ? `BMV_PROD_W'(0) : (num * mv) / den;
      scale = q[`BMV_MV_W-1:0];
   endfunction

   bmv_st_t s_reg;
   bmv_st_t s_next;

   logic                          is_bwd;
   logic signed [`BMV_MV_W-1:0]   cand_x [`BMV_NB_NUM];
   logic signed [`BMV_MV_W-1:0]   cand_y [`BMV_NB_NUM];
   logic signed [`BMV_MV_W-1:0]   pred_x;
   logic signed [`BMV_MV_W-1:0]   pred_y;
   logic signed [`BMV_PROD_W-1:0] tr_b;
   logic signed [`BMV_PROD_W-1:0] tr_d;
   logic signed [`BMV_PROD_W-1:0] ref_off;
   logic [`BMV_REF_W-1:0]         dir_ref;

   assign is_bwd = (s_reg.state == BMV_BWD);

   // Neighbour candidates of the direction being predicted
   genvar g;
   generate
      for (g = 0; g < `BMV_NB_NUM; g++) begin : g_cand
         logic ok;
         assign ok = is_bwd ? nb_bwd_ok_i[g] : nb_fwd_ok_i[g];
         assign cand_x[g] = !ok ? '0 : (is_bwd ? nb_bwd_x_i[g] : nb_fwd_x_i[g]);
         assign cand_y[g] = !ok ? '0 : (is_bwd ? nb_bwd_y_i[g] : nb_fwd_y_i[g]);
      end
   endgenerate

   // Later sub-blocks replace the left candidate with the previous sub-block vector
   assign pred_x = med3((s_reg.cnt == '0) ? cand_x[0] : s_reg.last_x, cand_x[1], cand_x[2]);
   assign pred_y = med3((s_reg.cnt == '0) ? cand_y[0] : s_reg.last_y, cand_y[1], cand_y[2]);

   // Temporal distances, stretched to the co-located reference when multi-reference
   assign dir_ref = multi_ref_i ? col_ref_i : '0;
   assign ref_off = `BMV_PROD_W'(dir_ref) * `BMV_PROD_W'(ref_gap_i);
   assign tr_b    = `BMV_PROD_W'(cur_to_prev_distance_i) + ref_off;
   assign tr_d    = `BMV_PROD_W'(prev_to_next_distance_i) + ref_off;

   // Next-state and output computation
   always_comb begin
      s_next          = s_reg;
      s_next.mv_valid = 1'b0;
      s_next.mb_done  = 1'b0;
      unique case (s_reg.state)
         BMV_IDLE: begin
            if (mb_start_i) begin
               s_next.cnt     = '0;
               s_next.col_idx = '0;
               s_next.phase   = 1'b0;
               s_next.last_x  = '0;
               s_next.last_y  = '0;
               s_next.fwd_ref = multi_ref_i ? ref_frame_i : '0;
               if (macroblock_kind_i == `BMV_KIND_DIRECT) begin
                  s_next.state    = BMV_DIR;
                  s_next.zero_dir = col_intra_i | next_ref_intra_i;
                  s_next.shape    = col_size_i;
                  s_next.total    = blk_count(col_size_i);
               end else if (macroblock_kind_i == `BMV_KIND_BIDIR) begin
                  s_next.state     = BMV_FWD;
                  s_next.shape     = fwd_blk_size_i;
                  s_next.total     = blk_count(fwd_blk_size_i);
                  s_next.bwd_shape = bwd_blk_size_i;
                  s_next.need_bwd  = 1'b1;
               end else if (macroblock_kind_i <= `BMV_KIND_LAST_UNI) begin
                  // Kinds 1/2 are fwd/bwd; from 4 up the even codes are forward
                  s_next.state    = (macroblock_kind_i[0] == (macroblock_kind_i < `BMV_KIND_BIDIR))
                                    ? BMV_FWD : BMV_BWD;
                  s_next.shape    = uni_size(macroblock_kind_i);
                  s_next.total    = blk_count(uni_size(macroblock_kind_i));
                  s_next.need_bwd = 1'b0;
               end else begin
                  s_next.mb_done = 1'b1;   // Intra: no vectors
               end
            end
         end
         BMV_FWD,
         BMV_BWD: begin
            if (vd_valid_i && s_reg.vd_ready) begin
               s_next.mv_valid = 1'b1;
               s_next.mv_dir   = is_bwd;
               s_next.mv_blk   = s_reg.cnt[`BMV_IDX_W-1:0];
               s_next.mv_shape = s_reg.shape;
               s_next.mv_x     = pred_x + (is_bwd ? bwd_vector_diff_x_i
                                                  : fwd_vector_diff_x_i);
               s_next.mv_y     = pred_y + (is_bwd ? bwd_vector_diff_y_i
                                                  : fwd_vector_diff_y_i);
               s_next.mv_ref   = is_bwd ? '0 : s_reg.fwd_ref;
               s_next.last_x   = s_next.mv_x;
               s_next.last_y   = s_next.mv_y;
               s_next.cnt      = s_reg.cnt + `BMV_CNT_W'(1);
               if (s_next.cnt == s_reg.total) begin
                  s_next.cnt    = '0;
                  s_next.last_x = '0;
                  s_next.last_y = '0;
                  if (!is_bwd && s_reg.need_bwd) begin
                     s_next.state    = BMV_BWD;
                     s_next.shape    = s_reg.bwd_shape;
                     s_next.total    = blk_count(s_reg.bwd_shape);
                     s_next.need_bwd = 1'b0;
                  end else begin
                     s_next.state   = BMV_IDLE;
                     s_next.mb_done = 1'b1;
                  end
               end
            end
         end
         BMV_DIR: begin
            s_next.mv_valid = 1'b1;
            s_next.mv_blk   = s_reg.cnt[`BMV_IDX_W-1:0];
            s_next.mv_shape = s_reg.shape;
            if (!s_reg.phase) begin
               s_next.mv_dir = 1'b0;
               s_next.mv_ref = dir_ref;
               s_next.mv_x   = s_reg.zero_dir ? '0 :
                               scale(tr_b, `BMV_PROD_W'(col_mv_x_i), tr_d);
               s_next.mv_y   = s_reg.zero_dir ? '0 :
                               scale(tr_b, `BMV_PROD_W'(col_mv_y_i), tr_d);
               s_next.pend_x = s_reg.zero_dir ? '0 :
                               scale(tr_b - tr_d, `BMV_PROD_W'(col_mv_x_i), tr_d);
               s_next.pend_y = s_reg.zero_dir ? '0 :
                               scale(tr_b - tr_d, `BMV_PROD_W'(col_mv_y_i), tr_d);
               s_next.phase  = 1'b1;
            end else begin
               s_next.mv_dir  = 1'b1;
               s_next.mv_ref  = '0;
               s_next.mv_x    = s_reg.pend_x;
               s_next.mv_y    = s_reg.pend_y;
               s_next.phase   = 1'b0;
               s_next.cnt     = s_reg.cnt + `BMV_CNT_W'(1);
               s_next.col_idx = s_next.cnt[`BMV_IDX_W-1:0];
               if (s_next.cnt == s_reg.total) begin
                  s_next.cnt     = '0;
                  s_next.col_idx = '0;
                  s_next.state   = BMV_IDLE;
                  s_next.mb_done = 1'b1;
               end
            end
         end
      endcase
      s_next.vd_ready = (s_next.state == BMV_FWD) || (s_next.state == BMV_BWD);
      s_next.busy     = (s_next.state != BMV_IDLE);
   end

   // State register with clock enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg       <= '0;
         s_reg.state <= BMV_IDLE;
      end else if (ce_i) begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state register
   assign vd_ready_o = s_reg.vd_ready;
   assign busy_o     = s_reg.busy;
   assign col_idx_o  = s_reg.col_idx;
   assign mv_valid_o = s_reg.mv_valid;
   assign mv_dir_o   = s_reg.mv_dir;
   assign mv_blk_o   = s_reg.mv_blk;
   assign mv_shape_o = s_reg.mv_shape;
   assign mv_x_o     = s_reg.mv_x;
   assign mv_y_o     = s_reg.mv_y;
   assign mv_ref_o   = s_reg.mv_ref;
   assign mb_done_o  = s_reg.mb_done;

endmodule
`default_nettype wire

// ==== dv/bmv_derive_sva.sv ====
// Port checker for the motion vector derivation block
`timescale 1ns/1ps
`default_nettype none
module bmv_derive_sva (
   input wire logic              clk_i,
   input wire logic              rst_i,
   input wire logic              ce_i,
   input wire logic              mb_start_i,
   input wire logic [4:0]        macroblock_kind_i,
   input wire logic              col_intra_i,
   input wire logic              next_ref_intra_i,
   input wire logic              vd_valid_i,
   input wire logic              vd_ready_o,
   input wire logic              busy_o,
   input wire logic [3:0]        col_idx_o,
   input wire logic              mv_valid_o,
   input wire logic              mv_dir_o,
   input wire logic signed [11:0] mv_x_o,
   input wire logic signed [11:0] mv_y_o,
   input wire logic [3:0]        mv_ref_o,
   input wire logic              mb_done_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Start of a direct macroblock
   sequence s_dir;
      ce_i && !busy_o && mb_start_i && macroblock_kind_i == 5'h00;
   endsequence
   a_start_busy:
      assert property (ce_i && !busy_o && mb_start_i && macroblock_kind_i < 5'h10 |=> busy_o)
      else $error("inter start not taken");
   a_diff_ready:
      assert property (ce_i && !busy_o && mb_start_i && macroblock_kind_i != 5'h00
         && macroblock_kind_i < 5'h04 |=> vd_ready_o) else $error("no ready for data");
   a_direct_nodata:
      assert property (s_dir |=> busy_o && !vd_ready_o) else $error("direct asks for data");
   a_set_answer:
      assert property (ce_i && vd_valid_i && vd_ready_o |=> mv_valid_o)
      else $error("set gave no vector");
   a_direct_pair:
      assert property (s_dir ##0 ce_i [*3] |-> mv_valid_o && !mv_dir_o ##1 mv_valid_o && mv_dir_o)
      else $error("direct pair missing");
   a_direct_col:
      assert property (s_dir |=> col_idx_o == 4'h0) else $error("first lookup not block 0");
   a_intra_zero:
      assert property (s_dir ##0 (col_intra_i || next_ref_intra_i) ##0 ce_i [*3]
         |-> (mv_x_o == 12'h000 && mv_y_o == 12'h000) [*2]) else $error("intra not zero");
   a_bwd_ref:
      assert property (mv_valid_o && mv_dir_o |-> mv_ref_o == 4'h0) else $error("bwd ref set");
   a_hold_vec:
      assert property (!mv_valid_o |-> $stable(mv_x_o) && $stable(mv_y_o))
      else $error("vector moved");
   a_done_idle:
      assert property (mb_done_o |-> !busy_o && !vd_ready_o) else $error("done while busy");
endmodule
`default_nettype wire

// ==== dv/bmv_col_store.sv ====
// Co-located vector store model answering direct-mode lookups
`timescale 1ns/1ps
`default_nettype none
module bmv_col_store (
   input  wire logic [3:0]         col_idx_i,
   output logic signed [11:0]      col_mv_x_o,
   output logic signed [11:0]      col_mv_y_o
);
   // Ramp through zero so negative products are exercised
   always_comb begin
      col_mv_x_o = 12'(7 * int'(col_idx_i) - 20);
      col_mv_y_o = 12'(5 - 3 * int'(col_idx_i));
   end
endmodule
`default_nettype wire

// ==== dv/bmv_derive_test.sv ====
// Self-checking bench for the motion vector derivation block
`timescale 1ns/1ps
`default_nettype none
module bmv_derive_test;
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, mb_start_i = 1'b0, vd_valid_i = 1'b0;
   logic multi_ref_i = 1'b0, col_intra_i = 1'b0, next_ref_intra_i = 1'b0;
   logic [4:0] macroblock_kind_i = 5'h00;
   logic [2:0] fwd_blk_size_i = 3'h0, bwd_blk_size_i = 3'h0, col_size_i = 3'h0;
   logic [2:0] nb_fwd_ok_i = 3'h7, nb_bwd_ok_i = 3'h7;
   logic [3:0] ref_frame_i = 4'h0, col_ref_i = 4'h2;
   logic [7:0] cur_to_prev_distance_i = 8'h03, prev_to_next_distance_i = 8'h05, ref_gap_i = 8'h04;
   logic signed [11:0] fwd_vector_diff_x_i = 12'h000, fwd_vector_diff_y_i = 12'h000;
   logic signed [11:0] bwd_vector_diff_x_i = 12'h000, bwd_vector_diff_y_i = 12'h000;
   logic [2:0][11:0] nb_fwd_x_i = {12'h010, 12'h005, 12'hFF8};
   logic [2:0][11:0] nb_fwd_y_i = {12'hFFE, 12'h003, 12'h007};
   logic [2:0][11:0] nb_bwd_x_i = {12'h020, 12'hFE0, 12'h00C};
   logic [2:0][11:0] nb_bwd_y_i = {12'h001, 12'h002, 12'hFFD};
   wire logic vd_ready_o, busy_o, mv_valid_o, mv_dir_o, mb_done_o;
   wire logic [3:0] col_idx_o, mv_blk_o, mv_ref_o;
   wire logic [2:0] mv_shape_o;
   wire logic signed [11:0] mv_x_o, mv_y_o, col_mv_x_i, col_mv_y_i;
   logic [35:0] cap_q[$];
   int fail_count = 0;
   int checks = 0;
   bmv_derive dut_u (.clk_i, .rst_i, .ce_i, .mb_start_i, .macroblock_kind_i, .fwd_blk_size_i,
      .bwd_blk_size_i, .ref_frame_i, .multi_ref_i, .vd_valid_i, .fwd_vector_diff_x_i,
      .fwd_vector_diff_y_i, .bwd_vector_diff_x_i, .bwd_vector_diff_y_i, .nb_fwd_x_i, .nb_fwd_y_i,
      .nb_fwd_ok_i, .nb_bwd_x_i, .nb_bwd_y_i, .nb_bwd_ok_i, .col_size_i, .col_intra_i,
      .next_ref_intra_i, .col_ref_i, .col_mv_x_i, .col_mv_y_i, .cur_to_prev_distance_i,
      .prev_to_next_distance_i, .ref_gap_i, .vd_ready_o, .busy_o, .col_idx_o, .mv_valid_o,
      .mv_dir_o, .mv_blk_o, .mv_shape_o, .mv_x_o, .mv_y_o, .mv_ref_o, .mb_done_o);
   bmv_col_store store_u (.col_idx_i(col_idx_o), .col_mv_x_o(col_mv_x_i), .col_mv_y_o(col_mv_y_i));
   // Clock and capture of every vector pulse
   initial forever #50 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (mv_valid_o === 1'b1) begin
         cap_q.push_back({mv_dir_o, mv_blk_o, mv_shape_o, mv_ref_o, mv_x_o, mv_y_o});
      end
   end
   task automatic final_report();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [35:0] pk(int d, int b, int s, int r, int x, int y);
      return {1'(d), 4'(b), 3'(s), 4'(r), 12'(x), 12'(y)};
   endfunction
   function automatic int cnt(int s);
      return (s == 0) ? 1 : (s < 3) ? 2 : (s == 3) ? 4 : (s < 6) ? 8 : 16;
   endfunction
   function automatic int med(int a, int b, int c);
      return (a > b) ? ((b > c) ? b : ((a > c) ? c : a)) : ((a > c) ? a : ((b > c) ? c : b));
   endfunction
   // Neighbour component, zero where the neighbour lacks that direction
   function automatic int nbr(bit d, bit y, int i);
      logic [2:0][11:0] v;
      logic [2:0] ok;
      v = d ? (y ? nb_bwd_y_i : nb_bwd_x_i) : (y ? nb_fwd_y_i : nb_fwd_x_i);
      ok = d ? nb_bwd_ok_i : nb_fwd_ok_i;
      return ok[i] ? int'($signed(v[i])) : 0;
   endfunction
   task automatic start(int k, int fs, int bs);
      @(negedge clk_i);
      cap_q.delete();
      macroblock_kind_i = 5'(k);
      fwd_blk_size_i = 3'(fs);
      bwd_blk_size_i = 3'(bs);
      mb_start_i = 1'b1;
      @(negedge clk_i);
      mb_start_i = 1'b0;
   endtask
   // Set j carries fwd (3j+1, -2j) and bwd (40-j, 9+j)
   task automatic send(int n);
      int j;
      int t;
      for (j = 0; j < n; j++) begin
         for (t = 0; t < 20 && vd_ready_o !== 1'b1; t++) @(negedge clk_i);
         if (t == 20) begin
            fail_count++;
            final_report();
         end
         vd_valid_i = 1'b1;
         fwd_vector_diff_x_i = 12'(3 * j + 1);
         fwd_vector_diff_y_i = 12'(-2 * j);
         bwd_vector_diff_x_i = 12'(40 - j);
         bwd_vector_diff_y_i = 12'(9 + j);
         @(negedge clk_i);
      end
      vd_valid_i = 1'b0;
   endtask
   task automatic wait_done();
      int i;
      for (i = 0; i < 200 && mb_done_o !== 1'b1; i++) @(negedge clk_i);
      if (i == 200) begin
         fail_count++;
         final_report();
      end
      @(negedge clk_i);
   endtask
   task automatic exp_dir(bit d, int n, int s, int r, int j0, int q0);
      int k;
      int px;
      int py;
      for (k = 0; k < n; k++) begin
         px = med(k > 0 ? px : nbr(d, 0, 0), nbr(d, 0, 1), nbr(d, 0, 2));
         py = med(k > 0 ? py : nbr(d, 1, 0), nbr(d, 1, 1), nbr(d, 1, 2));
         px = px + (d ? 40 - j0 - k : 3 * (j0 + k) + 1);
         py = py + (d ? 9 + j0 + k : -2 * (j0 + k));
         check(cap_q[q0 + k], pk(d, k, s, r, px, py));
      end
   endtask
   // Single-direction kinds, with a clock-enable freeze before the data
   task automatic t_uni(int k);
      bit d;
      int s;
      int n;
      d = (k == 2) || (k > 3 && k % 2 == 1);
      s = (k < 4) ? 0 : k / 2 - 1;
      n = cnt(s);
      multi_ref_i = 1'b1;
      ref_frame_i = 4'h5;
      nb_bwd_ok_i = 3'h2;
      start(k, 0, 0);
      ce_i = 1'b0;
      vd_valid_i = 1'b1;
      repeat (3) @(negedge clk_i);
      check(36'(cap_q.size()), 36'h0);
      ce_i = 1'b1;
      send(n);
      wait_done();
      check(36'(cap_q.size()), 36'(n));
      exp_dir(d, n, s, d ? 0 : 5, 0, 0);
   endtask
   // Reset in mid-macroblock drops the rest of it
   task automatic t_reset();
      start(3, 6, 6);
      send(3);
      rst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      rst_i = 1'b0;
      check(36'({busy_o, vd_ready_o, mv_valid_o, mb_done_o}), 36'h0);
      check(36'(cap_q.size()), 36'h3);
   endtask
   // Intra kind takes no difference data
   task automatic t_intra();
      vd_valid_i = 1'b1;
      start(17, 0, 0);
      wait_done();
      vd_valid_i = 1'b0;
      check(36'(cap_q.size()), 36'h0);
   endtask
   // Every bi size code, forward sets before backward sets
   task automatic t_bi();
      int s;
      int nf;
      int nk;
      for (s = 0; s < 7; s++) begin
         nf = cnt(s);
         nk = cnt(6 - s);
         multi_ref_i = s[0];
         ref_frame_i = 4'(s);
         nb_fwd_ok_i = 3'(s + 1);
         nb_bwd_ok_i = 3'(6 - s);
         start(3, s, 6 - s);
         send(nf + nk);
         wait_done();
         check(36'(cap_q.size()), 36'(nf + nk));
         exp_dir(0, nf, s, s[0] ? s : 0, 0, 0);
         exp_dir(1, nk, 6 - s, 0, nf, nf);
      end
   endtask
   task automatic t_direct(int cs, bit mr, bit ci, bit ni);
      int k;
      int e;
      int f;
      int dd;
      col_size_i = 3'(cs);
      multi_ref_i = mr;
      col_intra_i = ci;
      next_ref_intra_i = ni;
      dd = mr ? 13 : 5;
      e = (ci || ni) ? 0 : dd - 2;
      f = (ci || ni) ? 0 : -2;
      start(0, 0, 0);
      wait_done();
      check(36'(cap_q.size()), 36'(2 * cnt(cs)));
      for (k = 0; k < cnt(cs); k++) begin
         check(cap_q[2 * k], pk(0, k, cs, mr ? 2 : 0, e * (7 * k - 20) / dd, e * (5 - 3 * k) / dd));
         check(cap_q[2 * k + 1], pk(1, k, cs, 0, f * (7 * k - 20) / dd, f * (5 - 3 * k) / dd));
      end
   endtask
   // Main sequence
   initial begin
      repeat (20) @(negedge clk_i);
      rst_i = 1'b0;
      t_uni(1);
      t_uni(2);
      t_uni(4);
      t_uni(15);
      t_bi();
      t_reset();
      t_direct(3, 1'b0, 1'b0, 1'b0);
      t_direct(6, 1'b1, 1'b0, 1'b0);
      t_direct(1, 1'b1, 1'b1, 1'b0);
      t_direct(0, 1'b0, 1'b0, 1'b1);
      t_intra();
      final_report();
   end
endmodule
bind bmv_derive bmv_derive_sva sva_u (.clk_i, .rst_i, .ce_i, .mb_start_i, .macroblock_kind_i,
   .col_intra_i, .next_ref_intra_i, .vd_valid_i, .vd_ready_o, .busy_o, .col_idx_o, .mv_valid_o,
   .mv_dir_o, .mv_x_o, .mv_y_o, .mv_ref_o, .mb_done_o);
`default_nettype wire
